// *** rtl/dci_ctl.sv ***
// Controller end: makes the link clock by division and sequences commands.
// Assumes the user issues a refresh with cke_req low only when all banks are idle.
`timescale 1ns/100ps
module dci_ctl (
   input  wire logic                     core_clk,
   input  wire logic                     sys_rst,
   input  wire logic                     ce,
   input  wire logic                     cmd_valid,
   output logic                          cmd_ready,
   input  wire logic [3:0]               cmd_op,
   input  wire logic [dci_pkg::BA_W-1:0] cmd_ba,
   input  wire logic [dci_pkg::A_W-1:0]  cmd_addr,
   input  wire logic                     cke_req,
   input  wire logic                     odt_req,
   input  wire logic                     wr_valid,
   output logic                          wr_ready,
   input  wire logic [dci_pkg::DQ_W-1:0] wr_data,
   input  wire logic                     wr_mask,
   output logic                          rd_valid,
   output logic [dci_pkg::DQ_W-1:0]      rd_data,
   dci_if.ctl                            pin
);
   logic [2:0]  phase, next_phase;
   logic [3:0]  cnt, next_cnt;
   logic [dci_pkg::DQ_W-1:0] dq_s1, dq_s2;
   dci_pkg::dci_ctl_t state, next_state;
   logic        f_valid, f_ready;
   logic [dci_pkg::DQ_W:0]   f_data;
   logic        launch, take, next_rd_valid, next_cmd_ready;
   logic [3:0]  next_code;
   logic [3:0]  burst_beats;

   dci_fifo #(.W(dci_pkg::DQ_W + 1), .D(dci_pkg::FIFO_D)) u_wfifo (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .ce        (ce),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .in_data   ({wr_mask, wr_data}),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );

   // ======================================================================
   // Sequencer; pins change one core cycle after the link clock falls.
   always_comb begin
      next_phase    = (phase == dci_pkg::PH_LAST) ? 3'h0 : 3'(phase + 3'h1);
      launch        = phase == dci_pkg::PH_FALL;
      take          = cmd_valid && cmd_ready;
      next_state    = state;
      next_cnt      = cnt;
      next_code     = dci_pkg::CMD_DES;
      next_rd_valid = 1'b0;
      f_ready       = 1'b0;
      if (take) begin
         next_code = cmd_op;
         if (cmd_op == dci_pkg::CMD_WR || cmd_op == dci_pkg::CMD_RD) begin
            next_cnt   = cmd_addr[dci_pkg::A_BC] ? dci_pkg::BEATS_BL8 : dci_pkg::BEATS_BC4;
            next_state = (cmd_op == dci_pkg::CMD_WR) ? dci_pkg::DCI_WRB : dci_pkg::DCI_RDB;
            if (cmd_op == dci_pkg::CMD_RD) begin
               next_cnt = 4'(next_cnt + dci_pkg::RD_SKIP);
            end
         end
      end
      case (state)
         dci_pkg::DCI_WRB: begin
            if (launch) begin
               if (cnt == 4'h0) begin
                  next_state = dci_pkg::DCI_IDLE;
               end else begin
                  f_ready  = 1'b1;
                  next_cnt = 4'(cnt - 4'h1);
               end
            end
         end
         dci_pkg::DCI_RDB: begin
            if (phase == dci_pkg::PH_LAST) begin
               // Beats are captured only after the two skipped periods of read latency.
               next_rd_valid = cnt <= burst_beats;
               next_cnt      = 4'(cnt - 4'h1);
               if (cnt == 4'h1) begin
                  next_state = dci_pkg::DCI_IDLE;
               end
            end
         end
         default: ;
      endcase
      next_cmd_ready = next_phase == dci_pkg::PH_FALL && next_state == dci_pkg::DCI_IDLE;
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase           <= 3'h0;
         state           <= dci_pkg::DCI_IDLE;
         cnt             <= 4'h0;
         burst_beats     <= 4'h0;
         cmd_ready       <= 1'b0;
         rd_valid        <= 1'b0;
         rd_data         <= '0;
         dq_s1           <= '0;
         dq_s2           <= '0;
         pin.ck          <= 1'b0;
         pin.ck_n        <= 1'b1;
         pin.reset_n     <= 1'b0;
         pin.cke         <= 1'b0;
         pin.odt         <= 1'b0;
         {pin.cs_n, pin.ras_n, pin.cas_n, pin.we_n} <= dci_pkg::CMD_DES;
         pin.ba          <= '0;
         pin.addr        <= '0;
         pin.dm          <= 1'b1;
         pin.ctl_dq_o    <= '0;
         pin.ctl_dq_oe_n <= 1'b1;
      end else if (ce) begin
         phase       <= next_phase;
         state       <= next_state;
         cnt         <= next_cnt;
         cmd_ready   <= next_cmd_ready;
         rd_valid    <= next_rd_valid;
         dq_s1       <= pin.dq;
         dq_s2       <= dq_s1;
         pin.ck      <= next_phase < dci_pkg::PH_FALL;
         pin.ck_n    <= next_phase >= dci_pkg::PH_FALL;
         pin.reset_n <= 1'b1;
         if (take) begin
            burst_beats <= cmd_addr[dci_pkg::A_BC] ? dci_pkg::BEATS_BL8 : dci_pkg::BEATS_BC4;
         end
         if (next_rd_valid) begin
            rd_data <= dq_s2;
         end
         if (launch) begin
            {pin.cs_n, pin.ras_n, pin.cas_n, pin.we_n} <= next_code;
            pin.cke         <= cke_req;
            pin.odt         <= odt_req;
            pin.ba          <= take ? cmd_ba : '0;
            pin.addr        <= take ? cmd_addr : '0;
            pin.ctl_dq_oe_n <= !f_ready;
            pin.ctl_dq_o    <= f_data[dci_pkg::DQ_W-1:0];
            pin.dm          <= !(f_ready && f_valid) || f_data[dci_pkg::DQ_W];
         end
      end
   end
endmodule // dci_ctl

// *** rtl/dci_dev.sv ***
// Device end: a behavioural x16 DDR3L command decoder with a small data array.
// Assumes all pins arrive from the controller's clock domain; all but ck_n are synchronised here.
`timescale 1ns/100ps

// Summary of operation
// - One x16 device, sixteen data lines.
// - Controller runs the memory clock at 6.25MHz.
// - Read/write take column, A10 auto-precharge; activate row.
// - Precharge closes one bank, or all if A10.
// - Load mode writes MR0..MR3 chosen by bank lines.
// - Bank lines address every bank command.
// - With on-the-fly chop, A12 picks BL8 or BC4.
// - Inputs sampled at clock rise; strobe aligned there.
// - Registered CKE enables or stops internal clocks.
// - CKE low: precharge/self refresh if idle, else active.
// - CKE synchronous except self-refresh exit, which is asynchronous.
// - Power-down listens only to clock, CKE, reset, ODT.
// - Self refresh listens only to CKE and reset.
// - Commands decoded only when chip select low.
// - Chip select is part of the command code.
// - Write beats with mask high are discarded.
// - Registered ODT switches termination on or off.
// - Termination only on data, strobe, mask pins.
// - ODT ignored when termination disabled by mode.
module dci_dev (
   input  wire logic                       core_clk,
   input  wire logic                       sys_rst,
   input  wire logic                       ce,
   output dci_pkg::dci_pwr_t               pwr_state,
   output logic                            clk_on,
   output logic                            term_on,
   output logic [dci_pkg::BANKS-1:0]       banks_open,
   dci_if.dev                              pin
);
   localparam int PW = 5 + 4 + dci_pkg::BA_W + dci_pkg::A_W + dci_pkg::DQ_W;

   logic [PW-1:0]                  s1, s2;
   logic                           ck_d;
   logic                           ck_i, cke_i, odt_i, dm_i, rstn_i;
   logic [3:0]                     code;
   logic [dci_pkg::BA_W-1:0]       ba_i;
   logic [dci_pkg::A_W-1:0]        a_i;
   logic [dci_pkg::DQ_W-1:0]       dq_i;
   logic                           rise;

   logic [dci_pkg::DQ_W-1:0]       mem [0:(1 << dci_pkg::MEM_AW)-1];
   logic [15:0]                    mr [0:3];
   logic [15:0]                    row [0:dci_pkg::BANKS-1];
   dci_pkg::dci_pwr_t              next_pwr;
   logic [dci_pkg::BANKS-1:0]      next_open;
   logic                           next_clk_on, next_term;
   logic [3:0]                     bcnt, next_bcnt;
   logic [2:0]                     boff, next_boff;
   logic [2:0]                     bba, next_bba;
   logic [2:0]                     bcol, next_bcol;
   logic                           brd, next_brd;
   logic                           mr_we;
   logic [1:0]                     mr_sel;
   logic                           row_we;
   logic                           mem_we;
   logic [dci_pkg::MEM_AW-1:0]     midx;
   logic                           next_oe_n, next_dqs;
   logic [dci_pkg::DQ_W-1:0]       next_dq;
   logic                           rtt_en;

   // Array index of the current burst beat; only rows that differ in their two low bits are kept apart.
   function automatic logic [dci_pkg::MEM_AW-1:0] beat_index(input logic [2:0] b,
                                                             input logic [1:0] r,
                                                             input logic [2:0] c,
                                                             input logic [2:0] o);
      beat_index = {b, r, 3'(c + o)};
   endfunction

   // ======================================================================
   // Pin synchronisers
   // Every pin but ck_n passes two flops; the third copy of the clock finds its edges.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1   <= '0;
         s2   <= '0;
         ck_d <= 1'b0;
      end else if (ce) begin
         s1   <= {pin.ck, pin.cke, pin.odt, pin.dm, pin.reset_n,
                  pin.cs_n, pin.ras_n, pin.cas_n, pin.we_n, pin.ba, pin.addr, pin.dq};
         s2   <= s1;
         ck_d <= s2[PW-1];
      end
   end

   assign {ck_i, cke_i, odt_i, dm_i, rstn_i, code, ba_i, a_i, dq_i} = s2;
   assign rise   = ck_i && !ck_d;
   assign rtt_en = mr[1][dci_pkg::MR1_RTT0] || mr[1][dci_pkg::MR1_RTT1] || mr[1][dci_pkg::MR1_RTT2];
   assign midx   = beat_index(bba, row[bba][1:0], bcol, boff);

   // ======================================================================
   // Command, power and burst control
   always_comb begin
      next_pwr    = pwr_state;
      next_open   = banks_open;
      next_clk_on = clk_on;
      next_term   = term_on;
      next_bcnt   = bcnt;
      next_boff   = boff;
      next_bba    = bba;
      next_bcol   = bcol;
      next_brd    = brd;
      next_oe_n   = pin.dev_dq_oe_n;
      next_dqs    = pin.dqs_o;
      next_dq     = pin.dev_dq_o;
      mr_we       = 1'b0;
      mr_sel      = ba_i[1:0];
      row_we      = 1'b0;
      mem_we      = 1'b0;
      if (!rstn_i) begin
         next_pwr    = dci_pkg::DCI_NORM;
         next_open   = '0;
         next_clk_on = 1'b0;
         next_term   = 1'b0;
         next_bcnt   = 4'h0;
         next_oe_n   = 1'b1;
      end else if (pwr_state == dci_pkg::DCI_SREF) begin
         // The clock may stop here, so exit watches the CKE level alone.
         next_term = 1'b0;
         if (cke_i) begin
            next_pwr    = dci_pkg::DCI_NORM;
            next_clk_on = 1'b1;
         end
      end else if (rise) begin
         if (rtt_en) begin
            next_term = odt_i;
         end else begin
            next_term = 1'b0;
         end
         next_clk_on = cke_i;
         if (pwr_state != dci_pkg::DCI_NORM) begin
            if (cke_i) begin
               next_pwr = dci_pkg::DCI_NORM;
            end
         end else if (!cke_i) begin
            next_bcnt = 4'h0;
            next_oe_n = 1'b1;
            if (code == dci_pkg::CMD_REF && banks_open == '0) begin
               next_pwr  = dci_pkg::DCI_SREF;
               next_term = 1'b0;
            end else if (banks_open != '0) begin
               next_pwr = dci_pkg::DCI_APD;
            end else begin
               next_pwr = dci_pkg::DCI_PPD;
            end
         end else begin
            // Burst beats; a new command below may restart the burst.
            next_oe_n = !(brd && bcnt != 4'h0);
            if (bcnt != 4'h0) begin
               next_bcnt = 4'(bcnt - 4'h1);
               next_boff = 3'(boff + 3'h1);
               if (brd) begin
                  next_dq  = mem[midx];
                  next_dqs = !pin.dqs_o;
               end else begin
                  mem_we = !dm_i;
               end
            end else begin
               next_dqs = 1'b0;
            end
            case (code)
               dci_pkg::CMD_ACT: begin
                  row_we                  = 1'b1;
                  next_open[ba_i]         = 1'b1;
               end
               dci_pkg::CMD_RD, dci_pkg::CMD_WR: begin
                  next_bba  = ba_i;
                  next_bcol = a_i[2:0];
                  next_boff = 3'h0;
                  next_brd  = code == dci_pkg::CMD_RD;
                  if (mr[0][1:0] == dci_pkg::MR_BL_OTF) begin
                     next_bcnt = a_i[dci_pkg::A_BC] ? dci_pkg::BEATS_BL8 : dci_pkg::BEATS_BC4;
                  end else if (mr[0][1:0] == dci_pkg::MR_BL_BC4) begin
                     next_bcnt = dci_pkg::BEATS_BC4;
                  end else begin
                     next_bcnt = dci_pkg::BEATS_BL8;
                  end
                  if (a_i[dci_pkg::A_AP]) begin
                     next_open[ba_i] = 1'b0;
                  end
               end
               dci_pkg::CMD_PRE: begin
                  if (a_i[dci_pkg::A_AP]) begin
                     next_open = '0;
                  end else begin
                     next_open[ba_i] = 1'b0;
                  end
               end
               dci_pkg::CMD_LMR: begin
                  mr_we = !ba_i[2];
               end
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pwr_state       <= dci_pkg::DCI_NORM;
         banks_open      <= '0;
         clk_on          <= 1'b0;
         term_on         <= 1'b0;
         bcnt            <= 4'h0;
         boff            <= 3'h0;
         bba             <= 3'h0;
         bcol            <= 3'h0;
         brd             <= 1'b0;
         pin.dev_dq_oe_n <= 1'b1;
         pin.dqs_oe_n    <= 1'b1;
         pin.dqs_o       <= 1'b0;
         pin.dev_dq_o    <= '0;
         for (int i = 0; i < 4; i++) begin
            mr[i] <= dci_pkg::MR_RST;
         end
      end else if (ce) begin
         pwr_state       <= next_pwr;
         banks_open      <= next_open;
         clk_on          <= next_clk_on;
         term_on         <= next_term;
         bcnt            <= next_bcnt;
         boff            <= next_boff;
         bba             <= next_bba;
         bcol            <= next_bcol;
         brd             <= next_brd;
         pin.dev_dq_oe_n <= next_oe_n;
         pin.dqs_oe_n    <= next_oe_n;
         pin.dqs_o       <= next_dqs;
         pin.dev_dq_o    <= next_dq;
         if (mr_we) begin
            mr[mr_sel] <= a_i;
         end
      end
   end

   // ======================================================================
   // Storage
   // The array is far smaller than the part; only bank, low row and column bits index it.
   always_ff @(posedge core_clk) begin
      if (ce && row_we) begin
         row[ba_i] <= a_i;
      end
      if (ce && mem_we) begin
         mem[midx] <= dq_i;
      end
   end
endmodule // dci_dev

// *** rtl/dci_fifo.sv ***
// Write-data FIFO with valid/ready on both sides.
// Same clock on both sides; ready and valid come from flip-flops.
`timescale 1ns/100ps
module dci_fifo #(
   parameter int W = 17,
   parameter int D = 16
) (
   input  wire logic         core_clk,
   input  wire logic         sys_rst,
   input  wire logic         ce,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem [0:D-1];
   logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
   logic [AW:0]   cnt, next_cnt;
   logic          push, pop;

   // ======================================================================
   // Next state
   always_comb begin
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      next_wptr = push ? AW'(wptr + 1'b1) : wptr;
      next_rptr = pop ? AW'(rptr + 1'b1) : rptr;
      next_cnt  = (AW+1)'(cnt + push - pop);
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wptr      <= '0;
         rptr      <= '0;
         cnt       <= '0;
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
      end else if (ce) begin
         wptr      <= next_wptr;
         rptr      <= next_rptr;
         cnt       <= next_cnt;
         in_ready  <= next_cnt != (AW+1)'(D);
         out_valid <= next_cnt != '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (ce && push) begin
         mem[wptr] <= in_data;
      end
   end

   assign out_data = mem[rptr];
endmodule // dci_fifo

// *** rtl/dci_if.sv ***
// Pin bundle between the memory controller end and the memory device end.
// The shared data wire is resolved here from the two output enables.
`timescale 1ns/100ps
interface dci_if;
   logic                         ck;
   logic                         ck_n;
   logic                         cke;
   logic                         cs_n;
   logic                         ras_n;
   logic                         cas_n;
   logic                         we_n;
   logic [dci_pkg::BA_W-1:0]     ba;
   logic [dci_pkg::A_W-1:0]      addr;
   logic                         odt;
   logic                         dm;
   logic                         reset_n;
   logic [dci_pkg::DQ_W-1:0]     ctl_dq_o;
   logic                         ctl_dq_oe_n;
   logic [dci_pkg::DQ_W-1:0]     dev_dq_o;
   logic                         dev_dq_oe_n;
   logic                         dqs_o;
   logic                         dqs_oe_n;
   logic [dci_pkg::DQ_W-1:0]     dq;

   // A floating bus reads as zero.
   assign dq = !ctl_dq_oe_n ? ctl_dq_o : (!dev_dq_oe_n ? dev_dq_o : '0);

   modport ctl (output ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm, reset_n,
                output ctl_dq_o, ctl_dq_oe_n, input dq, dqs_o, dqs_oe_n);
   modport dev (input ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm, reset_n,
                input dq, output dev_dq_o, dev_dq_oe_n, dqs_o, dqs_oe_n);
endinterface

// *** rtl/dci_pkg.sv ***
// Shared constants and types for both ends of the x16 DDR3L command link.
// Assumes a single core clock of 50 MHz at each end; the link clock runs slower.
package dci_pkg;
   // =====================================================================
   // Widths
   localparam int DQ_W     = 16;
   localparam int A_W      = 16;
   localparam int BA_W     = 3;
   localparam int BANKS    = 8;
   localparam int MEM_AW   = 8;
   localparam int FIFO_D   = 16;
   // =====================================================================
   // Link clock timing
   localparam int CLK_NS       = 20;
   localparam int CK_PERIOD_NS = 160;
   localparam int CK_DIV       = CK_PERIOD_NS / CLK_NS;
   localparam logic [2:0] PH_FALL = 3'(CK_DIV / 2);
   localparam logic [2:0] PH_LAST = 3'(CK_DIV - 1);
   // =====================================================================
   // Command codes {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_LMR = 4'h0;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_WR  = 4'h4;
   localparam logic [3:0] CMD_RD  = 4'h5;
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_DES = 4'hf;
   // =====================================================================
   // Address fields and mode register fields
   localparam int A_AP   = 10;
   localparam int A_BC   = 12;
   localparam logic [1:0] MR_BL_OTF = 2'h1;
   localparam logic [1:0] MR_BL_BC4 = 2'h2;
   localparam int MR1_RTT0 = 2;
   localparam int MR1_RTT1 = 6;
   localparam int MR1_RTT2 = 9;
   localparam logic [15:0] MR_RST = 16'h0000;
   localparam logic [3:0] BEATS_BL8 = 4'h8;
   localparam logic [3:0] BEATS_BC4 = 4'h4;
   localparam logic [3:0] RD_SKIP   = 4'h2;
   // =====================================================================
   // States
   typedef enum logic [1:0] {
      DCI_NORM = 2'b00,
      DCI_APD  = 2'b01,
      DCI_PPD  = 2'b10,
      DCI_SREF = 2'b11
   } dci_pwr_t;
   typedef enum logic [1:0] {
      DCI_IDLE = 2'b00,
      DCI_WRB  = 2'b01,
      DCI_RDB  = 2'b10
   } dci_ctl_t;
endpackage

// *** tb/dci_properties.sv ***
// Concurrent checks on the link pins between the two ends.
// Assumes the signals of dci_if plus the core clock and reset.
`timescale 1ns/100ps
module dci_properties (
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        ck,
   input wire logic        ck_n,
   input wire logic        cke,
   input wire logic        cs_n,
   input wire logic        ras_n,
   input wire logic        cas_n,
   input wire logic        we_n,
   input wire logic [2:0]  ba,
   input wire logic [15:0] addr,
   input wire logic        odt,
   input wire logic        reset_n,
   input wire logic        ctl_dq_oe_n,
   input wire logic        dev_dq_oe_n,
   input wire logic        dqs_oe_n,
   input wire logic [15:0] dq
);
   // =====================================================================
   // Pin relations
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   a_ck_pair: assert property (ck_n == !ck) else $error("clock pair not complementary");
   a_ck_period: assert property ($fell(ck) |-> ##8 $fell(ck)) else $error("link clock period wrong");
   a_cmd_stands: assert property ($fell(cs_n) |=> $stable({ras_n, cas_n, we_n, ba, addr})[*7])
      else $error("command not held a link period");
   a_pins_at_fall: assert property ($changed({cs_n, cke, odt}) |-> !ck && $past(ck, 2))
      else $error("control pin moved away from clock fall");
   a_one_driver: assert property (ctl_dq_oe_n || dev_dq_oe_n) else $error("both ends drive data");
   a_wr_beat: assert property ($fell(ctl_dq_oe_n) |=> $stable(dq)[*7]) else $error("write beat short");
   a_dqs_with_data: assert property (!dev_dq_oe_n |-> !dqs_oe_n) else $error("read data without strobe");
   a_dev_quiet: assert property (!reset_n |-> dev_dq_oe_n) else $error("device drives in reset");
endmodule // dci_properties

// *** tb/test_ddr3l_command_pin_interface.sv ***
// Testbench joining both ends through dci_if, with a reference memory model.
// Assumes the package constants and a 50 MHz core clock.
`timescale 1ns/100ps
module test_ddr3l_command_pin_interface;
   logic              core_clk = 1'b0;
   logic              sys_rst  = 1'b1;
   logic              cmd_valid = 1'b0, cke_req = 1'b1, odt_req = 1'b1, wr_valid = 1'b0, wr_mask = 1'b0;
   logic [3:0]        cmd_op   = 4'hf;
   logic [2:0]        cmd_ba   = 3'h0;
   logic [15:0]       cmd_addr = 16'h0, wr_data = 16'h0, rd_data, mem [8];
   logic              cmd_ready, wr_ready, rd_valid, clk_on, term_on;
   logic [7:0]        banks_open;
   dci_pkg::dci_pwr_t pwr_state;
   int                fail_count = 0, tests_run = 0;
   always #10 core_clk = ~core_clk;
   dci_if i_dci_if ();
   dci_ctl i_dci_ctl (.core_clk(core_clk), .sys_rst(sys_rst), .ce(1'b1), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_ba(cmd_ba), .cmd_addr(cmd_addr), .cke_req(cke_req),
      .odt_req(odt_req), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .wr_mask(wr_mask),
      .rd_valid(rd_valid), .rd_data(rd_data), .pin(i_dci_if.ctl));
   dci_dev i_dci_dev (.core_clk(core_clk), .sys_rst(sys_rst), .ce(1'b1), .pwr_state(pwr_state),
      .clk_on(clk_on), .term_on(term_on), .banks_open(banks_open), .pin(i_dci_if.dev));
   dci_properties i_dci_properties (.core_clk(core_clk), .sys_rst(sys_rst), .ck(i_dci_if.ck),
      .ck_n(i_dci_if.ck_n), .cke(i_dci_if.cke), .cs_n(i_dci_if.cs_n), .ras_n(i_dci_if.ras_n),
      .cas_n(i_dci_if.cas_n), .we_n(i_dci_if.we_n), .ba(i_dci_if.ba), .addr(i_dci_if.addr), .odt(i_dci_if.odt),
      .reset_n(i_dci_if.reset_n), .ctl_dq_oe_n(i_dci_if.ctl_dq_oe_n), .dev_dq_oe_n(i_dci_if.dev_dq_oe_n),
      .dqs_oe_n(i_dci_if.dqs_oe_n), .dq(i_dci_if.dq));
   // =====================================================================
   // Tasks
   task check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task send(input logic [3:0] op, input logic [2:0] b, input logic [15:0] a, input logic c = 1'b1);
      int n;
      n = 0;
      @(posedge core_clk);
      {cmd_op, cmd_ba, cmd_addr, cke_req, cmd_valid} <= {op, b, a, c, 1'b1};
      do @(negedge core_clk); while (cmd_ready !== 1'b1 && ++n < 200);
      if (cmd_ready !== 1'b1) fail_count++;
      @(posedge core_clk);
      cmd_valid <= 1'b0;
   endtask
   // Masked beats leave the model untouched, as the device must.
   task burst(input logic [7:0] m);
      int n;
      for (int k = 0; k < 8; k++) begin
         n = 0;
         @(posedge core_clk);
         {wr_data, wr_mask, wr_valid} <= {16'($urandom), m[k], 1'b1};
         do @(negedge core_clk); while (wr_ready !== 1'b1 && ++n < 200);
         if (wr_ready !== 1'b1) fail_count++;
         if (!m[k]) mem[k] = wr_data;
         @(posedge core_clk);
         wr_valid <= 1'b0;
      end
      send(dci_pkg::CMD_WR, 3'h0, 16'h1000);
   endtask
   task read(input logic [15:0] a, input int beats);
      int n;
      send(dci_pkg::CMD_RD, 3'h0, a);
      for (int k = 0; k < beats; k++) begin
         n = 0;
         do @(negedge core_clk); while (rd_valid !== 1'b1 && ++n < 100);
         check(16'(rd_valid), 16'h0001);
         check(rd_data, mem[k]);
      end
   endtask
   task step(input logic [3:0] op, input logic [15:0] a, input logic c, input dci_pkg::dci_pwr_t exp);
      send(op, 3'h0, a, c);
      repeat (40) @(posedge core_clk);
      check(16'(pwr_state), 16'(exp));
      check(16'(clk_on), 16'(c));
   endtask
   task finish_test();
      $display("checks=%0d mismatches=%0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // =====================================================================
   // Sequence
   initial begin
      void'($urandom(32'h2abbbc0d));
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (40) @(posedge core_clk);
      check(16'(term_on), 16'h0);
      send(dci_pkg::CMD_LMR, 3'h0, 16'h0001);
      send(dci_pkg::CMD_LMR, 3'h1, 16'h0004);
      send(dci_pkg::CMD_ACT, 3'h0, 16'h0000);
      send(dci_pkg::CMD_ACT, 3'h5, 16'h0000);
      send(4'hb, 3'h6, 16'h0000);
      send(dci_pkg::CMD_PRE, 3'h5, 16'h0000);
      repeat (30) @(posedge core_clk);
      check(16'(banks_open), 16'h0001);
      check(16'(term_on), 16'h0001);
      burst(8'h00);
      burst(8'haa);
      read(16'h1000, 8);
      read(16'h0400, 4);
      check(16'(banks_open), 16'h0000);
      send(dci_pkg::CMD_ACT, 3'h0, 16'h0000);
      step(dci_pkg::CMD_REF, 16'h0000, 1'b0, dci_pkg::DCI_APD);
      step(dci_pkg::CMD_NOP, 16'h0000, 1'b1, dci_pkg::DCI_NORM);
      step(dci_pkg::CMD_PRE, 16'h0400, 1'b1, dci_pkg::DCI_NORM);
      check(16'(banks_open), 16'h0000);
      step(dci_pkg::CMD_NOP, 16'h0000, 1'b0, dci_pkg::DCI_PPD);
      step(dci_pkg::CMD_NOP, 16'h0000, 1'b1, dci_pkg::DCI_NORM);
      step(dci_pkg::CMD_REF, 16'h0000, 1'b0, dci_pkg::DCI_SREF);
      step(dci_pkg::CMD_NOP, 16'h0000, 1'b1, dci_pkg::DCI_NORM);
      finish_test();
   end
   // A hang is cut well past the expected run of under a thousand cycles.
   initial begin
      #400000;
      fail_count++;
      finish_test();
   end
endmodule // test_ddr3l_command_pin_interface
